// ---- hw/input_gain_path_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module input_gain_path_control #(
  parameter int TO_BASE_CYC = 256,
  parameter int MEAS_CYC = 1000
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // analogue comparators, asynchronous
  input wire logic zero_cross_left_i,
  input wire logic zero_cross_right_i,
  input wire logic hook_short_raw_i,
  // power controls
  output logic left_input_path_enable_o,
  output logic right_input_path_enable_o,
  output logic left_gain_stage_enable_o,
  output logic right_gain_stage_enable_o,
  output logic left_boost_mixer_enable_o,
  output logic right_boost_mixer_enable_o,
  output logic converter_highpass_disable_o,
  // active gain and mute
  output logic [input_gain_pkg::GAIN_W-1:0] left_gain_o,
  output logic [input_gain_pkg::GAIN_W-1:0] right_gain_o,
  output logic left_gain_stage_mute_o,
  output logic right_gain_stage_mute_o,
  // routing and mixers
  output logic [input_gain_pkg::ROUTE_W-1:0] left_route_o,
  output logic [input_gain_pkg::ROUTE_W-1:0] right_route_o,
  output logic [input_gain_pkg::MIX_W-1:0] left_boost_mixer_o,
  output logic [input_gain_pkg::MIX_W-1:0] right_boost_mixer_o,
  // detection
  output logic detach_fourth_inputs_o,
  output logic hook_short_o
);
  localparam int GW = input_gain_pkg::GAIN_W;
  localparam int MW = input_gain_pkg::MIX_W;
  localparam int PW = input_gain_pkg::POWER_W;
  localparam int DW = input_gain_pkg::TODIV_W;
  localparam int MCW = $clog2(MEAS_CYC);

  logic [PW-1:0] power_ff, nxt_power;
  logic [GW-1:0] lgain_ff, nxt_lgain, rgain_ff, nxt_rgain;
  logic lmute_ff, nxt_lmute, rmute_ff, nxt_rmute;
  logic [7:0] route_ff, nxt_route;
  logic [MW-1:0] lmix_ff, nxt_lmix, rmix_ff, nxt_rmix;
  logic [DW-1:0] todiv_ff, nxt_todiv;
  logic [15:0] detach_ff, nxt_detach, key_ff, nxt_key;
  logic ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat, rdata, wm;
  logic [7:0] idx;
  logic req, wr, vu;
  logic [2:0] s1_ff, s2_ff;
  logic [15:0] to_cnt_ff, nxt_to_cnt, to_period;
  logic to_tick;
  logic [MCW-1:0] meas_cnt_ff, nxt_meas_cnt;
  logic meas_tick;
  logic [GW-1:0] lgain_act, rgain_act;
  logic lmute_act, rmute_act, lpend, rpend, hook_evt;

  // merge write data into a word under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i+:8] = wd[8*i+:8];
      end
    end
    return r;
  endfunction

  // two-stage synchronisers for comparator inputs
  generate
    for (genvar g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          s1_ff[g] <= 1'b0;
          s2_ff[g] <= 1'b0;
        end else begin
          s1_ff[g] <= (g == 0) ? zero_cross_left_i :
                      (g == 1) ? zero_cross_right_i : hook_short_raw_i;
          s2_ff[g] <= s1_ff[g];
        end
      end
    end
  endgenerate

  // bus request decode
  assign idx = wb_adr_i[9:2];
  assign req = wb_cyc_i && wb_stb_i;
  assign wr = req && wb_we_i && ack_ff;
  assign wm = merge(rdata, wb_dat_i, wb_sel_i);
  assign vu = wr && wm[input_gain_pkg::VB_VU] &&
              (idx == input_gain_pkg::IDX_LVOL ||
               idx == input_gain_pkg::IDX_RVOL);

  // read mux, stored values not active ones, except status which reads the active ones
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (idx)
      input_gain_pkg::IDX_POWER: rdata[PW-1:0] = power_ff;
      input_gain_pkg::IDX_LVOL: begin
        rdata[GW-1:0] = lgain_ff;
        rdata[input_gain_pkg::VB_MUTE] = lmute_ff;
      end
      input_gain_pkg::IDX_RVOL: begin
        rdata[GW-1:0] = rgain_ff;
        rdata[input_gain_pkg::VB_MUTE] = rmute_ff;
      end
      input_gain_pkg::IDX_ROUTE: rdata[7:0] = route_ff;
      input_gain_pkg::IDX_LMIX: rdata[MW-1:0] = lmix_ff;
      input_gain_pkg::IDX_RMIX: rdata[MW-1:0] = rmix_ff;
      input_gain_pkg::IDX_TOCLK: rdata[DW-1:0] = todiv_ff;
      input_gain_pkg::IDX_STATUS: begin
        rdata[GW-1:0] = lgain_act;
        rdata[2*GW-1:GW] = rgain_act;
        rdata[12] = lmute_act;
        rdata[13] = rmute_act;
        rdata[14] = lpend;
        rdata[15] = rpend;
        rdata[16] = hook_evt;
      end
      input_gain_pkg::IDX_DETACH: rdata[15:0] = detach_ff;
      input_gain_pkg::IDX_KEY: rdata[15:0] = key_ff;
      default: rdata = 32'h0000_0000; // unmapped reads zero
    endcase
  end

  // register writes and bus answer
  always_comb begin
    nxt_power = power_ff;
    nxt_lgain = lgain_ff;
    nxt_rgain = rgain_ff;
    nxt_lmute = lmute_ff;
    nxt_rmute = rmute_ff;
    nxt_route = route_ff;
    nxt_lmix = lmix_ff;
    nxt_rmix = rmix_ff;
    nxt_todiv = todiv_ff;
    nxt_detach = detach_ff;
    nxt_key = key_ff;
    nxt_ack = req && !ack_ff;
    nxt_dat = (req && !ack_ff) ? rdata : dat_ff;
    if (wr) begin
      unique case (idx)
        input_gain_pkg::IDX_POWER: nxt_power = wm[PW-1:0];
        input_gain_pkg::IDX_LVOL: begin
          nxt_lgain = wm[GW-1:0];
          nxt_lmute = wm[input_gain_pkg::VB_MUTE];
        end
        input_gain_pkg::IDX_RVOL: begin
          nxt_rgain = wm[GW-1:0];
          nxt_rmute = wm[input_gain_pkg::VB_MUTE];
        end
        input_gain_pkg::IDX_ROUTE: nxt_route = wm[7:0];
        input_gain_pkg::IDX_LMIX: nxt_lmix = wm[MW-1:0];
        input_gain_pkg::IDX_RMIX: nxt_rmix = wm[MW-1:0];
        input_gain_pkg::IDX_TOCLK: nxt_todiv = wm[DW-1:0];
        input_gain_pkg::IDX_DETACH: begin
          if (key_ff == input_gain_pkg::KEY_UNLOCK) begin
            nxt_detach = wm[15:0];
          end
        end
        input_gain_pkg::IDX_KEY: nxt_key = wm[15:0];
        default: nxt_key = key_ff; // unmapped writes ignored
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_ff <= '0;
      lgain_ff <= input_gain_pkg::GAIN_RST;
      rgain_ff <= input_gain_pkg::GAIN_RST;
      lmute_ff <= 1'b0;
      rmute_ff <= 1'b0;
      route_ff <= 8'h00;
      lmix_ff <= '0;
      rmix_ff <= '0;
      todiv_ff <= '0;
      detach_ff <= 16'h0000;
      key_ff <= 16'h0000;
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      power_ff <= nxt_power;
      lgain_ff <= nxt_lgain;
      rgain_ff <= nxt_rgain;
      lmute_ff <= nxt_lmute;
      rmute_ff <= nxt_rmute;
      route_ff <= nxt_route;
      lmix_ff <= nxt_lmix;
      rmix_ff <= nxt_rmix;
      todiv_ff <= nxt_todiv;
      detach_ff <= nxt_detach;
      key_ff <= nxt_key;
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
    end
  end

  // timeout clock: base period shifted by divider, off when disabled
  assign to_period = 16'(TO_BASE_CYC) << todiv_ff;
  assign to_tick = power_ff[input_gain_pkg::PB_TOEN] &&
                   (to_cnt_ff >= to_period - 16'h0001);
  always_comb begin
    nxt_to_cnt = to_cnt_ff + 16'h0001;
    if (!power_ff[input_gain_pkg::PB_TOEN] || to_tick) begin
      nxt_to_cnt = 16'h0000;
    end
  end

  // hook measurement rate
  assign meas_tick = (meas_cnt_ff == MCW'(MEAS_CYC - 1));
  always_comb begin
    nxt_meas_cnt = meas_tick ? '0 : meas_cnt_ff + 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      to_cnt_ff <= 16'h0000;
      meas_cnt_ff <= '0;
    end else begin
      to_cnt_ff <= nxt_to_cnt;
      meas_cnt_ff <= nxt_meas_cnt;
    end
  end

  // per channel double-buffered gain, both loaded by one update
  gain_apply u_left (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(vu),
    .zc_enable_i(power_ff[input_gain_pkg::PB_ZCEN]),
    .zero_cross_i(s2_ff[0]),
    .timeout_tick_i(to_tick),
    .gain_i(nxt_lgain),
    .mute_i(nxt_lmute),
    .gain_o(lgain_act),
    .mute_o(lmute_act),
    .pending_o(lpend)
  );
  gain_apply u_right (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(vu),
    .zc_enable_i(power_ff[input_gain_pkg::PB_ZCEN]),
    .zero_cross_i(s2_ff[1]),
    .timeout_tick_i(to_tick),
    .gain_i(nxt_rgain),
    .mute_i(nxt_rmute),
    .gain_o(rgain_act),
    .mute_o(rmute_act),
    .pending_o(rpend)
  );

  // hook short filter
  short_filter #(.COUNT(input_gain_pkg::HOOK_COUNT)) u_hook (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(meas_tick),
    .sample_i(s2_ff[2]),
    .event_o(hook_evt)
  );

  // outputs
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign left_input_path_enable_o = power_ff[input_gain_pkg::PB_LIPE];
  assign right_input_path_enable_o = power_ff[input_gain_pkg::PB_RIPE];
  assign left_gain_stage_enable_o = power_ff[input_gain_pkg::PB_LGSE];
  assign right_gain_stage_enable_o = power_ff[input_gain_pkg::PB_RGSE];
  assign left_boost_mixer_enable_o = power_ff[input_gain_pkg::PB_LBME] ||
    power_ff[input_gain_pkg::PB_LIPE];
  assign right_boost_mixer_enable_o = power_ff[input_gain_pkg::PB_RBME] ||
    power_ff[input_gain_pkg::PB_RIPE];
  assign converter_highpass_disable_o = power_ff[input_gain_pkg::PB_HPFD];
  assign left_gain_o = lgain_act;
  assign right_gain_o = rgain_act;
  assign left_gain_stage_mute_o = lmute_act;
  assign right_gain_stage_mute_o = rmute_act;
  assign left_route_o = route_ff[3:0];
  assign right_route_o = route_ff[7:4];
  assign left_boost_mixer_o = lmix_ff;
  assign right_boost_mixer_o = rmix_ff;
  assign detach_fourth_inputs_o = detach_ff[input_gain_pkg::DETACH_BIT];
  assign hook_short_o = hook_evt;

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_hold_no_vu;
    !vu && !lpend |=> $stable(lgain_act) && $stable(lmute_act);
  endproperty
  a_hold_no_vu: assert property (p_hold_no_vu)
    else $error("gain changed without update");

  property p_both_load;
    vu && !power_ff[input_gain_pkg::PB_ZCEN] |=>
      lgain_act == lgain_ff && rgain_act == rgain_ff;
  endproperty
  a_both_load: assert property (p_both_load)
    else $error("update did not load both gains");

  property p_mute_load;
    vu && !power_ff[input_gain_pkg::PB_ZCEN] |=>
      lmute_act == lmute_ff && rmute_act == rmute_ff;
  endproperty
  a_mute_load: assert property (p_mute_load)
    else $error("update did not load both mutes");

  property p_zc_defer;
    vu && power_ff[input_gain_pkg::PB_ZCEN] |=> lpend && rpend;
  endproperty
  a_zc_defer: assert property (p_zc_defer)
    else $error("gain not deferred under zero-cross gating");

  property p_timeout_apply;
    lpend && to_tick && !vu |=> !lpend;
  endproperty
  a_timeout_apply: assert property (p_timeout_apply)
    else $error("pending gain not applied at timeout");

  property p_toclk_off;
    !power_ff[input_gain_pkg::PB_TOEN] |-> !to_tick;
  endproperty
  a_toclk_off: assert property (p_toclk_off)
    else $error("timeout tick while timeout clock disabled");

  property p_mixer_en;
    power_ff[input_gain_pkg::PB_LIPE] |-> left_boost_mixer_enable_o;
  endproperty
  a_mixer_en: assert property (p_mixer_en)
    else $error("left mixer off while input path enabled");

  property p_hook_drop;
    meas_tick && !s2_ff[2] |=> !hook_short_o;
  endproperty
  a_hook_drop: assert property (p_hook_drop)
    else $error("hook short held after a clear measurement");

  property p_detach_lock;
    wr && idx == input_gain_pkg::IDX_DETACH &&
      key_ff != input_gain_pkg::KEY_UNLOCK |=> $stable(detach_ff);
  endproperty
  a_detach_lock: assert property (p_detach_lock)
    else $error("detach written while locked");

  property p_read_stored;
    req && !ack_ff && !wb_we_i && idx == input_gain_pkg::IDX_LVOL |=>
      wb_ack_o && wb_dat_o[GW-1:0] == lgain_ff;
  endproperty
  a_read_stored: assert property (p_read_stored)
    else $error("gain read did not return stored value");

  c_zc_update: cover property (vu && power_ff[input_gain_pkg::PB_ZCEN]);
  c_timeout: cover property (lpend && to_tick);
  c_hook: cover property ($rose(hook_short_o));
  c_detach: cover property ($rose(detach_fourth_inputs_o));
endmodule
`default_nettype wire

// ---- hw/input_gain_pkg.sv ----
// Contract
// - each gain stage gain spans -23.25dB to +24dB in 0.75dB steps
// - each gain stage has its own mute bit
// - with zero-cross gating on, new gain waits for a zero crossing
// - with gating on and no crossing, pending gain applies at timeout
// - timeout clock runs only when enabled; divider field sets period
// - gain written with update bit 0 is stored, not applied
// - update bit on either channel loads both stored gains together; with gating on each applies at its own crossing
// - mute changes take effect only on an update bit write
// - four enable bits power the input paths and gain stages
// - boost mixer enabled by own bit or by its input path enable
// - boost mixer sources: gain stage, second and third input pairs
// - direct second and third pair mixer gain spans -12dB to +6dB
// - gain stage path mixer gain spans 0dB to +29dB
// - routing bits can disconnect every input pin from its stage
// - hook short signalled after 10 consecutive filtered measurements
package input_gain_pkg;
  localparam int GAIN_W = 6;
  localparam int MIX_W = 12;
  localparam int ROUTE_W = 4;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_POWER = 8'h00;
  localparam logic [7:0] IDX_LVOL = 8'h01;
  localparam logic [7:0] IDX_RVOL = 8'h02;
  localparam logic [7:0] IDX_ROUTE = 8'h03;
  localparam logic [7:0] IDX_LMIX = 8'h04;
  localparam logic [7:0] IDX_RMIX = 8'h05;
  localparam logic [7:0] IDX_TOCLK = 8'h06;
  localparam logic [7:0] IDX_STATUS = 8'h07;
  localparam logic [7:0] IDX_DETACH = 8'hCC;
  localparam logic [7:0] IDX_KEY = 8'hFD;
  // power register bits
  localparam int PB_LIPE = 0;
  localparam int PB_RIPE = 1;
  localparam int PB_LGSE = 2;
  localparam int PB_RGSE = 3;
  localparam int PB_LBME = 4;
  localparam int PB_RBME = 5;
  localparam int PB_TOEN = 6;
  localparam int PB_ZCEN = 7;
  localparam int PB_HPFD = 8;
  localparam int POWER_W = 9;
  // volume register fields
  localparam int VB_MUTE = 7;
  localparam int VB_VU = 8;
  localparam logic [GAIN_W-1:0] GAIN_RST = 6'h1F;
  localparam int TODIV_W = 3;
  localparam int DETACH_BIT = 6;
  localparam logic [15:0] KEY_UNLOCK = 16'h0001;
  localparam int HOOK_COUNT = 10;
endpackage

// ---- hw/gain_apply.sv ----
`timescale 1ns/1ps
`default_nettype none
module gain_apply (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic load_i,
  input wire logic zc_enable_i,
  input wire logic zero_cross_i,
  input wire logic timeout_tick_i,
  input wire logic [input_gain_pkg::GAIN_W-1:0] gain_i,
  input wire logic mute_i,
  // active state
  output logic [input_gain_pkg::GAIN_W-1:0] gain_o,
  output logic mute_o,
  output logic pending_o
);
  logic [input_gain_pkg::GAIN_W-1:0] gain_ff, nxt_gain, snap_ff, nxt_snap;
  logic mute_ff, nxt_mute, msnap_ff, nxt_msnap, pend_ff, nxt_pend;
  logic zc_prev_ff, zc_edge;

  assign zc_edge = zero_cross_i ^ zc_prev_ff;

  // snapshot on update, apply now or at crossing or timeout
  always_comb begin
    nxt_gain = gain_ff;
    nxt_mute = mute_ff;
    nxt_snap = snap_ff;
    nxt_msnap = msnap_ff;
    nxt_pend = pend_ff;
    if (pend_ff && (zc_edge || timeout_tick_i || !zc_enable_i)) begin
      nxt_gain = snap_ff;
      nxt_mute = msnap_ff;
      nxt_pend = 1'b0;
    end
    if (load_i && !zc_enable_i) begin
      nxt_gain = gain_i;
      nxt_mute = mute_i;
      nxt_pend = 1'b0;
    end else if (load_i) begin
      nxt_snap = gain_i;
      nxt_msnap = mute_i;
      nxt_pend = 1'b1; // set wins over apply
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_ff <= input_gain_pkg::GAIN_RST;
      snap_ff <= input_gain_pkg::GAIN_RST;
      mute_ff <= 1'b0;
      msnap_ff <= 1'b0;
      pend_ff <= 1'b0;
      zc_prev_ff <= 1'b0;
    end else begin
      gain_ff <= nxt_gain;
      snap_ff <= nxt_snap;
      mute_ff <= nxt_mute;
      msnap_ff <= nxt_msnap;
      pend_ff <= nxt_pend;
      zc_prev_ff <= zero_cross_i;
    end
  end

  assign gain_o = gain_ff;
  assign mute_o = mute_ff;
  assign pending_o = pend_ff;
endmodule
`default_nettype wire

// ---- hw/short_filter.sv ----
`timescale 1ns/1ps
`default_nettype none
module short_filter #(
  parameter int COUNT = input_gain_pkg::HOOK_COUNT
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // measurement
  input wire logic tick_i,
  input wire logic sample_i,
  output logic event_o
);
  logic [$clog2(COUNT+1)-1:0] cnt_ff, nxt_cnt;

  // count consecutive over-threshold samples, saturate at count
  always_comb begin
    nxt_cnt = cnt_ff;
    if (tick_i && !sample_i) begin
      nxt_cnt = '0;
    end else if (tick_i && cnt_ff != COUNT[$bits(cnt_ff)-1:0]) begin
      nxt_cnt = cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign event_o = (cnt_ff == COUNT[$bits(cnt_ff)-1:0]);
endmodule
`default_nettype wire

// ---- verification/analog_input_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module analog_input_model (
  // clock
  input wire logic clk_i,
  // bench requests
  input wire logic flip_left_i,
  input wire logic flip_right_i,
  input wire logic short_i,
  // comparator levels toward the block
  output logic zero_cross_left_o,
  output logic zero_cross_right_o,
  output logic hook_short_raw_o
);
  logic zl_ff = 1'b0;
  logic zr_ff = 1'b0;
  logic hs_ff = 1'b0;
  // one flip request is one signal crossing on that channel
  always @(posedge clk_i) begin
    zl_ff <= zl_ff ^ flip_left_i;
    zr_ff <= zr_ff ^ flip_right_i;
    hs_ff <= short_i; // current above the short threshold
  end
  // comparator outputs
  assign zero_cross_left_o = zl_ff;
  assign zero_cross_right_o = zr_ff;
  assign hook_short_raw_o = hs_ff;
endmodule
`default_nettype wire

// ---- verification/input_gain_path_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module input_gain_path_control_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [9:0] wb_adr_i = 10'h000;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o, rd, sd;
  logic wb_ack_o, zl, zr, hr, lm, rm, det, hook;
  logic flip_l = 1'b0;
  logic flip_r = 1'b0;
  logic short_in = 1'b0;
  logic lipe, ripe, lgse, rgse, lbme, rbme, hpfd;
  logic [5:0] lg, rg;
  logic [3:0] lrt, rrt;
  logic [11:0] lmx, rmx;
  int error_cnt = 0;
  int cmp_count = 0;
  // clock source
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  input_gain_path_control #(.TO_BASE_CYC(4), .MEAS_CYC(4))
      input_gain_path_control_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .zero_cross_left_i(zl), .zero_cross_right_i(zr), .hook_short_raw_i(hr),
    .left_input_path_enable_o(lipe), .right_input_path_enable_o(ripe),
    .left_gain_stage_enable_o(lgse), .right_gain_stage_enable_o(rgse),
    .left_boost_mixer_enable_o(lbme), .right_boost_mixer_enable_o(rbme),
    .converter_highpass_disable_o(hpfd), .left_gain_o(lg),
    .right_gain_o(rg), .left_gain_stage_mute_o(lm),
    .right_gain_stage_mute_o(rm), .left_route_o(lrt), .right_route_o(rrt),
    .left_boost_mixer_o(lmx), .right_boost_mixer_o(rmx),
    .detach_fourth_inputs_o(det), .hook_short_o(hook));
  analog_input_model analog_input_model_inst (
    .clk_i(clk_i), .flip_left_i(flip_l), .flip_right_i(flip_r),
    .short_i(short_in), .zero_cross_left_o(zl), .zero_cross_right_o(zr),
    .hook_short_raw_o(hr));
  // verdict and end of run
  task automatic wrap_up();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // xorshift source of stimulus
  function automatic logic [31:0] rnd();
    sd = sd ^ (sd << 13);
    sd = sd ^ (sd >> 17);
    sd = sd ^ (sd << 5);
    return sd;
  endfunction
  // volume register image
  function automatic logic [31:0] vol(logic u, logic m, logic [5:0] g);
    return {23'h0, u, m, 1'b0, g};
  endfunction
  // active state: hook, mutes, gains
  function automatic logic [14:0] obs();
    return {hook, rm, lm, rg, lg};
  endfunction
  // one classic wishbone cycle, entered just after a clock edge
  task automatic wb(logic we, logic [7:0] idx, logic [31:0] d,
                    logic [3:0] sel);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= d;
    wb_sel_i <= sel;
    n = 0;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (wb_ack_o !== 1'b1) begin
      error_cnt++;
      wrap_up();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // bounded wait for an expected active state
  task automatic wait_obs(logic [14:0] e, int lim);
    int n;
    n = 0;
    while (obs() !== e && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    chk(obs(), e);
    if (obs() !== e) wrap_up();
  endtask
  // main sequence
  initial begin
    logic [31:0] r;
    logic [5:0] g;
    logic [8:0] p;
    sd = 32'h9DC8EA8D;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(obs(), 15'h07DF);
    wb(1'b0, input_gain_pkg::IDX_STATUS, 32'h0, 4'hF);
    chk(rd, 32'h000007DF);
    // routing and mixers set while paths are off, then power fields
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      p = r[8:0] & 9'h17F;
      if (i == 0) r = 32'h0;
      r[3] = 1'b0;
      wb(1'b1, input_gain_pkg::IDX_ROUTE, r, 4'hF);
      wb(1'b1, input_gain_pkg::IDX_LMIX, r >> 8, 4'hF);
      wb(1'b1, input_gain_pkg::IDX_RMIX, r >> 20, 4'hF);
      chk({rrt, lrt}, r[7:0]);
      chk({rmx, lmx}, r[31:8]);
      // reference and bias are taken as up before the stages
      wb(1'b1, input_gain_pkg::IDX_POWER, {23'h0, p}, 4'hF);
      chk({hpfd, rbme, lbme, rgse, lgse, ripe, lipe},
          {p[8], p[5] | p[1], p[4] | p[0], p[3:0]});
      wb(1'b1, input_gain_pkg::IDX_POWER, 32'h0, 4'hF);
    end
    // stored versus applied gain and mute
    r = rnd();
    g = r[11:6];
    wb(1'b1, input_gain_pkg::IDX_LVOL, vol(1'b0, 1'b1, r[5:0]), 4'hF);
    wb(1'b1, input_gain_pkg::IDX_RVOL, vol(1'b0, 1'b0, g), 4'hF);
    chk(obs(), 15'h07DF);
    wb(1'b0, input_gain_pkg::IDX_LVOL, 32'h0, 4'hF);
    chk(rd, vol(1'b0, 1'b1, r[5:0]));
    wb(1'b1, input_gain_pkg::IDX_LVOL, vol(1'b1, 1'b1, r[5:0]), 4'hF);
    chk(obs(), {3'b001, g, r[5:0]});
    wb(1'b1, input_gain_pkg::IDX_RVOL, vol(1'b1, 1'b1, 6'h3F), 4'h1);
    chk(obs(), {3'b001, g, r[5:0]});
    wb(1'b1, input_gain_pkg::IDX_RVOL, vol(1'b1, 1'b1, 6'h3F), 4'h3);
    chk(obs(), {3'b011, 6'h3F, r[5:0]});
    // gated update, timeout clock stopped
    wb(1'b1, input_gain_pkg::IDX_POWER, 32'h80, 4'hF);
    wb(1'b1, input_gain_pkg::IDX_LVOL, vol(1'b0, 1'b0, 6'h00), 4'hF);
    wb(1'b1, input_gain_pkg::IDX_RVOL, vol(1'b1, 1'b0, 6'h3F), 4'hF);
    repeat (40) @(posedge clk_i);
    chk(obs(), {3'b011, 6'h3F, r[5:0]});
    wb(1'b0, input_gain_pkg::IDX_STATUS, 32'h0, 4'hF);
    chk(rd[15:14], 2'b11);
    flip_l <= 1'b1;
    @(posedge clk_i);
    flip_l <= 1'b0;
    wait_obs({3'b010, 6'h3F, 6'h00}, 10);
    flip_r <= 1'b1;
    @(posedge clk_i);
    flip_r <= 1'b0;
    wait_obs({3'b000, 6'h3F, 6'h00}, 10);
    // gated update released by the timeout clock
    for (int d = 0; d < 4; d += 3) begin
      r = rnd();
      wb(1'b1, input_gain_pkg::IDX_TOCLK, d, 4'hF);
      wb(1'b1, input_gain_pkg::IDX_POWER, 32'hC0, 4'hF);
      wb(1'b1, input_gain_pkg::IDX_LVOL, vol(1'b0, 1'b0, r[5:0]), 4'hF);
      wb(1'b1, input_gain_pkg::IDX_RVOL, vol(1'b1, 1'b0, r[11:6]), 4'hF);
      wait_obs({3'b000, r[11:0]}, (8 << d) + 8);
    end
    // keyed detach of the fourth inputs
    wb(1'b1, input_gain_pkg::IDX_DETACH, 32'h40, 4'hF);
    chk(det, 1'b0);
    wb(1'b1, input_gain_pkg::IDX_KEY, 32'h1, 4'hF);
    wb(1'b1, input_gain_pkg::IDX_DETACH, 32'h40, 4'hF);
    wb(1'b1, input_gain_pkg::IDX_KEY, 32'h0, 4'hF);
    chk(det, 1'b1);
    wb(1'b1, input_gain_pkg::IDX_DETACH, 32'h0, 4'hF);
    chk(det, 1'b1);
    // unmapped place reads zero
    wb(1'b1, 8'h20, 32'hFFFFFFFF, 4'hF);
    wb(1'b0, 8'h20, 32'h0, 4'hF);
    chk(rd, 32'h0);
    // hook short: a short burst, then a long one
    short_in <= 1'b1;
    repeat (24) @(posedge clk_i);
    short_in <= 1'b0;
    repeat (12) @(posedge clk_i);
    short_in <= 1'b1;
    repeat (30) @(posedge clk_i);
    chk(hook, 1'b0);
    wait_obs({1'b1, 2'b00, r[11:0]}, 40);
    short_in <= 1'b0;
    wait_obs({1'b0, 2'b00, r[11:0]}, 12);
    // button measurement: swap first left for fourth left, hpf off, 0dB
    wb(1'b1, input_gain_pkg::IDX_ROUTE, 32'h0, 4'hF);
    wb(1'b1, input_gain_pkg::IDX_ROUTE, 32'h8, 4'hF);
    chk(lrt, 4'h8);
    wb(1'b1, input_gain_pkg::IDX_POWER, 32'h100, 4'hF);
    wb(1'b1, input_gain_pkg::IDX_LVOL, vol(1'b1, 1'b0, 6'h1F), 4'hF);
    chk({hpfd, lg}, {1'b1, 6'h1F});
    // reset again in mid-run, everything back to idle
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(obs(), 15'h07DF);
    chk({det, hpfd, lrt}, 6'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
